// *** core/sat_desc_decode.sv ***
// splits a fetched segment descriptor into its fields
// assumes lo holds the word at the lower address
`timescale 1ns/1ns
module sat_desc_decode
    import sat_pkg::*;
(
    input  wire logic [31:0]       lo,
    input  wire logic [31:0]       hi,
    output logic      [ADDR_W-1:0] base,
    output logic      [3:0]        dtype,
    output logic                   is_seg,
    output logic      [1:0]        dpl,
    output logic                   present
);

    // ==========================================================
    // field extraction
    assign base    = {hi[D1_BASE_HI +: 8], hi[D1_BASE_MID +: 8],
                      lo[D0_BASE_LO +: 16]}; // RL3 RL12
    assign dtype   = hi[D1_TYPE_LO +: 4]; // RL3
    assign is_seg  = hi[D1_SEG_BIT];
    assign dpl     = hi[D1_DPL_LO +: 2]; // RL3
    assign present = hi[D1_PRES_BIT];

endmodule // sat_desc_decode

// *** core/sat_pkg.sv ***
// constants, types and selector helpers for segment address translation
// assumes a 32-bit linear space and a memory port returning 32-bit words
//
// Summary of operation
// RL1 - in protected mode every access goes through a global or local table descriptor
// RL2 - selector splits into table index, global/local flag and requested privilege
// RL3 - descriptor yields base address, access rights, type and usage bits
// RL4 - linear address is descriptor base plus offset; selector and offset always given
// RL5 - access allowed only for a valid descriptor reachable from current privilege
// RL6 - current privilege is the level of the executing code segment
// RL7 - global table found through its own base register holding a linear address
// RL8 - local table found through a separate base register holding its linear address
// RL9 - reset starts real-address mode; protected mode only on explicit request
// RL10 - an exception without an accurate error code reports code zero
// RL11 - memory is byte addressed; every access located by a byte address
// RL12 - multi-byte words are little-endian, least significant byte at lowest address
// RL13 - a failed check aborts the access with a general protection fault
package sat_pkg;

    localparam int ADDR_W     = 32;
    localparam int SEL_W      = 16;
    localparam int IDX_W      = 13;
    localparam int BE_W       = 4;

    // selector layout
    localparam int SEL_RPL_LO = 0;
    localparam int SEL_TI_BIT = 2;
    localparam int SEL_IDX_LO = 3;

    // descriptor layout: eight bytes, low word at the lower address
    localparam int DESC_SHIFT    = 3;
    localparam int D0_BASE_LO    = 16;
    localparam int D1_BASE_MID   = 0;
    localparam int D1_TYPE_LO    = 8;
    localparam int D1_SEG_BIT    = 12;
    localparam int D1_DPL_LO     = 13;
    localparam int D1_PRES_BIT   = 15;
    localparam int D1_BASE_HI    = 24;
    localparam int TYPE_CODE_BIT = 3;
    localparam int TYPE_RW_BIT   = 1;

    localparam logic [ADDR_W-1:0] HI_WORD_OFS = 32'h0000_0004;
    localparam int                REAL_SHIFT  = 4;

    localparam logic [1:0]        RESET_CPL   = 2'h0;
    localparam logic [SEL_W-1:0]  ERR_ZERO    = 16'h0000;
    localparam logic [SEL_W-1:0]  ERR_MASK    = 16'hfffc;
    localparam logic [ADDR_W-1:0] ADDR_ZERO   = 32'h0000_0000;

    // access size codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [BE_W-1:0] BE_BYTE = 4'h1;
    localparam logic [BE_W-1:0] BE_HALF = 4'h3;
    localparam logic [BE_W-1:0] BE_WORD = 4'hf;
    localparam logic [BE_W-1:0] BE_NONE = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RD_LO = 2'b01,
        ST_RD_HI = 2'b10,
        ST_CHECK = 2'b11
    } sat_state_t;

    function automatic logic [IDX_W-1:0] sel_index(input logic [SEL_W-1:0] s);
        sel_index = s[SEL_IDX_LO +: IDX_W];
    endfunction

    function automatic logic sel_is_local(input logic [SEL_W-1:0] s);
        sel_is_local = s[SEL_TI_BIT];
    endfunction

    function automatic logic [1:0] sel_rpl(input logic [SEL_W-1:0] s);
        sel_rpl = s[SEL_RPL_LO +: 2];
    endfunction

    function automatic logic [ADDR_W-1:0] desc_offset(input logic [SEL_W-1:0] s);
        desc_offset = ADDR_W'(sel_index(s)) << DESC_SHIFT;
    endfunction

    // lane 0 carries the byte at the lowest address
    function automatic logic [BE_W-1:0] be_of(input logic [1:0] sz, input logic [1:0] a);
        logic [BE_W-1:0] m;
        m = (sz == SZ_BYTE) ? BE_BYTE : (sz == SZ_HALF) ? BE_HALF : BE_WORD;
        be_of = BE_W'(m << a);
    endfunction

endpackage

// *** core/sat_translate.sv ***
// segment translation and protection check
// assumes memory answers each descriptor word read with a one-cycle mem_ack
`timescale 1ns/1ns
module sat_translate
    import sat_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              prot_enable,
    input  wire logic              gtb_wr,
    input  wire logic [ADDR_W-1:0] gtb_data,
    input  wire logic              ltb_wr,
    input  wire logic [ADDR_W-1:0] ltb_data,
    input  wire logic              req_valid,
    input  wire logic [SEL_W-1:0]  req_sel,
    input  wire logic [ADDR_W-1:0] req_off,
    input  wire logic [1:0]        req_size,
    input  wire logic              req_write,
    input  wire logic              req_cs_load,
    output logic                   req_ready_q,
    output logic                   mem_rd_q,
    output logic      [ADDR_W-1:0] mem_addr_q,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    output logic                   rsp_valid_q,
    output logic      [ADDR_W-1:0] rsp_lin_q,
    output logic      [BE_W-1:0]   rsp_be_q,
    output logic                   gp_fault_q,
    output logic      [SEL_W-1:0]  gp_err_q,
    output logic                   prot_mode_q,
    output logic      [1:0]        cpl_q
);

    // ==========================================================
    // declarations
    sat_state_t        state_q;
    sat_state_t        state_d;
    logic [ADDR_W-1:0] global_table_base_reg_q;
    logic [ADDR_W-1:0] local_table_base_reg_q;
    logic              ltb_valid_q;
    logic [SEL_W-1:0]  sel_q;
    logic [ADDR_W-1:0] off_q;
    logic [1:0]        size_q;
    logic              write_q;
    logic              csl_q;
    logic [ADDR_W-1:0] desc_addr_q;
    logic [31:0]       dw_lo_q;
    logic [31:0]       dw_hi_q;
    logic              accept;
    logic              null_sel;
    logic              no_local;
    logic              early_fault;
    logic [ADDR_W-1:0] desc_addr;
    logic [ADDR_W-1:0] real_lin;
    logic [ADDR_W-1:0] d_base;
    logic [3:0]        d_type;
    logic              d_seg;
    logic [1:0]        d_dpl;
    logic              d_pres;
    logic [1:0]        eff_pl;
    logic              is_code;
    logic              allowed;
    logic [ADDR_W-1:0] prot_lin;

    // ==========================================================
    // request decode
    assign accept   = req_valid && req_ready_q;
    assign null_sel = !sel_is_local(req_sel) && (sel_index(req_sel) == '0); // RL2
    assign no_local = sel_is_local(req_sel) && !ltb_valid_q; // RL2
    assign early_fault = null_sel || no_local;
    assign desc_addr = (sel_is_local(req_sel) ? local_table_base_reg_q
                                              : global_table_base_reg_q)
                       + desc_offset(req_sel); // RL1 RL7 RL8
    assign real_lin = (ADDR_W'(req_sel) << REAL_SHIFT) + req_off; // RL9 RL11

    // ==========================================================
    // descriptor fields
    sat_desc_decode sat_desc_decode_inst (
        .lo      (dw_lo_q),
        .hi      (dw_hi_q),
        .base    (d_base),
        .dtype   (d_type),
        .is_seg  (d_seg),
        .dpl     (d_dpl),
        .present (d_pres)
    );

    // ==========================================================
    // protection check
    assign eff_pl  = (sel_rpl(sel_q) > cpl_q) ? sel_rpl(sel_q) : cpl_q;
    assign is_code = d_type[TYPE_CODE_BIT];
    assign prot_lin = d_base + off_q; // RL4

    always_comb
    begin
        allowed = d_pres && d_seg; // RL5
        if (csl_q)
        begin
            allowed = allowed && is_code && (d_dpl >= cpl_q); // RL6
        end
        else if (is_code)
        begin
            allowed = allowed && !write_q && d_type[TYPE_RW_BIT] && (d_dpl >= cpl_q);
        end
        else
        begin
            allowed = allowed && (d_dpl >= eff_pl) && (!write_q || d_type[TYPE_RW_BIT]);
        end
    end

    // ==========================================================
    // sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (accept && prot_mode_q && !early_fault)
                begin
                    state_d = ST_RD_LO; // RL1
                end
            end
            ST_RD_LO:
            begin
                if (mem_ack)
                begin
                    state_d = ST_RD_HI;
                end
            end
            ST_RD_HI:
            begin
                if (mem_ack)
                begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q     <= ST_IDLE;
            req_ready_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            req_ready_q <= (state_d == ST_IDLE);
        end
    end

    // ==========================================================
    // mode and table base registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prot_mode_q <= 1'b0; // RL9
        end
        else if (prot_enable)
        begin
            prot_mode_q <= 1'b1; // RL9
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            global_table_base_reg_q <= ADDR_ZERO;
            local_table_base_reg_q  <= ADDR_ZERO;
            ltb_valid_q             <= 1'b0;
        end
        else
        begin
            if (gtb_wr)
            begin
                global_table_base_reg_q <= gtb_data; // RL7
            end
            if (ltb_wr)
            begin
                local_table_base_reg_q <= ltb_data; // RL8
                ltb_valid_q            <= 1'b1;
            end
        end
    end

    // ==========================================================
    // request capture and descriptor fetch
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sel_q       <= ERR_ZERO;
            off_q       <= ADDR_ZERO;
            size_q      <= SZ_BYTE;
            write_q     <= 1'b0;
            csl_q       <= 1'b0;
            desc_addr_q <= ADDR_ZERO;
        end
        else if (accept)
        begin
            sel_q       <= req_sel;
            off_q       <= req_off;
            size_q      <= req_size;
            write_q     <= req_write;
            csl_q       <= req_cs_load;
            desc_addr_q <= desc_addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mem_rd_q   <= 1'b0;
            mem_addr_q <= ADDR_ZERO;
            dw_lo_q    <= '0;
            dw_hi_q    <= '0;
        end
        else
        begin
            mem_rd_q <= (state_d != state_q)
                        && (state_d == ST_RD_LO || state_d == ST_RD_HI);
            if (state_q == ST_IDLE)
            begin
                mem_addr_q <= desc_addr;
            end
            else if (state_q == ST_RD_LO && mem_ack)
            begin
                mem_addr_q <= desc_addr_q + HI_WORD_OFS; // RL12
            end
            if (state_q == ST_RD_LO && mem_ack)
            begin
                dw_lo_q <= mem_rdata; // RL12
            end
            if (state_q == ST_RD_HI && mem_ack)
            begin
                dw_hi_q <= mem_rdata;
            end
        end
    end

    // ==========================================================
    // response and fault reporting
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rsp_valid_q <= 1'b0;
            rsp_lin_q   <= ADDR_ZERO;
            rsp_be_q    <= BE_NONE;
            gp_fault_q  <= 1'b0;
            gp_err_q    <= ERR_ZERO;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            gp_fault_q  <= 1'b0;
            if (state_q == ST_IDLE && accept && !prot_mode_q)
            begin
                rsp_valid_q <= 1'b1;
                rsp_lin_q   <= real_lin; // RL9
                rsp_be_q    <= be_of(req_size, real_lin[1:0]); // RL11 RL12
            end
            else if (state_q == ST_IDLE && accept && early_fault)
            begin
                rsp_valid_q <= 1'b1;
                gp_fault_q  <= 1'b1; // RL13
                gp_err_q    <= ERR_ZERO; // RL10
                rsp_lin_q   <= ADDR_ZERO;
                rsp_be_q    <= BE_NONE;
            end
            else if (state_q == ST_CHECK)
            begin
                rsp_valid_q <= 1'b1;
                if (allowed)
                begin
                    rsp_lin_q <= prot_lin; // RL4
                    rsp_be_q  <= csl_q ? BE_NONE : be_of(size_q, prot_lin[1:0]);
                end
                else
                begin
                    gp_fault_q <= 1'b1; // RL13
                    gp_err_q   <= sel_q & ERR_MASK;
                    rsp_lin_q  <= ADDR_ZERO;
                    rsp_be_q   <= BE_NONE;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cpl_q <= RESET_CPL;
        end
        else if (state_q == ST_CHECK && csl_q && allowed)
        begin
            cpl_q <= d_dpl; // RL6
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    fetch_route_a: assert property ( // RL1
        accept && prot_mode_q && !early_fault |=> mem_rd_q && mem_addr_q == $past(desc_addr))
        else $error("descriptor fetch not issued");

    no_local_a: assert property ( // RL2
        accept && prot_mode_q && no_local |=> gp_fault_q && gp_err_q == ERR_ZERO)
        else $error("local selector without local table not faulted");

    base_add_a: assert property ( // RL4
        $past(state_q) == ST_CHECK && !gp_fault_q |-> rsp_lin_q == $past(prot_lin))
        else $error("linear address is not base plus offset");

    priv_check_a: assert property ( // RL5
        $past(state_q) == ST_CHECK && rsp_valid_q && !gp_fault_q
        |-> $past(d_pres) && $past(d_seg) && $past(d_dpl) >= $past(cpl_q))
        else $error("access granted past the privilege check");

    cpl_update_a: assert property ( // RL6
        state_q == ST_CHECK && csl_q && allowed |=> cpl_q == $past(d_dpl) ##1 $stable(cpl_q))
        else $error("privilege level not taken from code segment");

    gtb_load_a: assert property ( // RL7
        gtb_wr ##1 !gtb_wr [*2] |-> global_table_base_reg_q == $past(gtb_data, 2))
        else $error("global table base not held");

    ltb_load_a: assert property ( // RL8
        ltb_wr |=> ltb_valid_q && local_table_base_reg_q == $past(ltb_data))
        else $error("local table base not loaded");

    real_mode_a: assert property ( // RL9
        accept && !prot_mode_q |=> rsp_valid_q && !gp_fault_q && !mem_rd_q
        && rsp_lin_q == $past(real_lin))
        else $error("real mode translation wrong");

    zero_err_a: assert property ( // RL10
        accept && prot_mode_q && null_sel |=> gp_fault_q && gp_err_q == ERR_ZERO)
        else $error("null selector error code not zero");

    byte_lane_a: assert property ( // RL11
        rsp_valid_q && !gp_fault_q && rsp_be_q != BE_NONE |-> rsp_be_q[rsp_lin_q[1:0]])
        else $error("first byte lane does not match byte address");

    fault_abort_a: assert property ( // RL13
        gp_fault_q |-> rsp_valid_q && rsp_lin_q == ADDR_ZERO && rsp_be_q == BE_NONE)
        else $error("faulted access still produced an address");

    real_acc_c: cover property (accept && !prot_mode_q);
    prot_ok_c:  cover property ($past(state_q) == ST_CHECK && !gp_fault_q);
    fault_c:    cover property (gp_fault_q && gp_err_q != ERR_ZERO);
    cs_load_c:  cover property (state_q == ST_CHECK && csl_q && allowed);

endmodule // sat_translate

// *** tb/sat_mem_model.sv ***
// memory model answering descriptor word reads of the translator
// assumes one outstanding read; lag sets the extra wait before each ack
`timescale 1ns/1ns
module sat_mem_model
(
    input  wire logic        clk,
    input  wire logic        mem_rd_q,
    input  wire logic [31:0] mem_addr_q,
    input  wire logic [1:0]  lag,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    // ==========================================
    // storage
    logic [31:0] words [logic [31:0]];
    logic [31:0] a;
    logic        busy;
    logic        ack_n;
    logic [31:0] data_n;
    int          wait_n;

    // low word at the lower address
    task automatic put_desc(input logic [31:0] ad, input logic [63:0] d);
        words[ad] = d[31:0];
        words[ad + 32'h4] = d[63:32];
    endtask

    // ==========================================
    // read answer
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 32'h5a5a_5a5a;
        busy = 1'b0;
        wait_n = 0;
        a = 32'h0;
        forever
        begin
            // look just after the edge so a read raised at that edge is seen
            @(posedge clk);
            #1;
            ack_n = 1'b0;
            // data is not held past the ack
            data_n = ~mem_rdata;
            if (mem_rd_q === 1'b1)
            begin
                a = mem_addr_q;
                wait_n = lag;
                busy = 1'b1;
            end
            if (busy && wait_n == 0)
            begin
                busy = 1'b0;
                ack_n = 1'b1;
                data_n = words.exists(a) ? words[a] : ~mem_rdata;
            end
            else if (busy)
            begin
                wait_n--;
            end
            mem_ack = ack_n;
            mem_rdata = data_n;
        end
    end
endmodule // sat_mem_model

// *** tb/sat_translate_test.sv ***
// self-checking bench for the segment translator
// assumes the memory model answers descriptor reads
`timescale 1ns/1ns
module sat_translate_test;
    import sat_pkg::*;

    typedef struct {logic f; logic [31:0] lin; logic [3:0] be; logic [15:0] err;} sat_exp_t;

    localparam logic [31:0] GTB = 32'h0001_0000;
    localparam logic [31:0] LTB = 32'h0002_0000;
    localparam logic [31:0] B1  = 32'h1234_5670;
    localparam logic [31:0] B2  = 32'h00a0_0003;
    localparam logic [31:0] B5  = 32'hc000_1000;

    logic        clk, nrst, prot_enable, gtb_wr, ltb_wr, req_valid, req_write, req_cs_load;
    logic [31:0] gtb_data, ltb_data, req_off, mem_addr_q, mem_rdata, rsp_lin_q;
    logic [15:0] req_sel, gp_err_q;
    logic [1:0]  req_size, cpl_q, lag;
    logic        req_ready_q, mem_rd_q, mem_ack, rsp_valid_q, gp_fault_q, prot_mode_q;
    logic [3:0]  rsp_be_q;
    int          fail_count, checks_done, seed, i;
    logic [31:0] o;
    logic [15:0] sv;
    sat_exp_t    exp_q[$];
    sat_exp_t    got;

    sat_translate sat_translate_inst (.clk(clk), .nrst(nrst), .prot_enable(prot_enable),
        .gtb_wr(gtb_wr), .gtb_data(gtb_data), .ltb_wr(ltb_wr), .ltb_data(ltb_data),
        .req_valid(req_valid), .req_sel(req_sel), .req_off(req_off), .req_size(req_size),
        .req_write(req_write), .req_cs_load(req_cs_load), .req_ready_q(req_ready_q),
        .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .rsp_valid_q(rsp_valid_q), .rsp_lin_q(rsp_lin_q),
        .rsp_be_q(rsp_be_q), .gp_fault_q(gp_fault_q), .gp_err_q(gp_err_q),
        .prot_mode_q(prot_mode_q), .cpl_q(cpl_q));

    sat_mem_model sat_mem_model_inst (.clk(clk), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ==========================================
    // helpers
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic conclude();
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [63:0] dsc(input logic [31:0] b, input logic [3:0] ty,
        input logic [1:0] dpl, input logic p);
        dsc = {b[31:24], 8'h00, p, dpl, 1'b1, ty, b[23:16], b[15:0], 16'hffff};
    endfunction

    function automatic logic [1:0] rsz();
        rsz = 2'($unsigned($random(seed)) % 3);
    endfunction

    task automatic send(input logic [15:0] s, input logic [31:0] of, input logic [1:0] sz,
        input logic wr, input logic cs, input logic f, input logic [31:0] b,
        input logic [15:0] err);
        sat_exp_t e;
        int n;
        logic [3:0] m;
        m = (sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h3 : 4'hf;
        e.f = f;
        e.lin = f ? 32'h0 : b + of;
        e.be = (f || cs) ? 4'h0 : 4'(m << e.lin[1:0]);
        e.err = err;
        exp_q.push_back(e);
        @(posedge clk);
        #1;
        lag = 2'($random(seed));
        req_valid = 1'b1;
        req_sel = s;
        req_off = of;
        req_size = sz;
        req_write = wr;
        req_cs_load = cs;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (req_ready_q !== 1'b1 && n < 60);
        if (n >= 60)
        begin
            cmp("ready_wait", 32'h1, 32'h0);
            conclude();
        end
        #1;
        req_valid = 1'b0;
        req_sel = ~s;
        req_off = ~of;
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 60 && exp_q.size() != 0; n++)
            @(posedge clk);
        if (exp_q.size() != 0)
        begin
            cmp("drain_wait", 32'h1, 32'h0);
            conclude();
        end
        @(posedge clk);
    endtask

    task automatic tbl(input logic loc, input logic [31:0] d);
        @(posedge clk);
        #1;
        if (loc) {ltb_wr, ltb_data} = {1'b1, d};
        else {gtb_wr, gtb_data} = {1'b1, d};
        @(posedge clk);
        #1;
        {gtb_wr, ltb_wr, prot_enable} = 3'h0;
    endtask

    // ==========================================
    // response monitor
    always @(posedge clk)
    begin
        if (rsp_valid_q === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp("extra_response", 32'h0, 32'h1);
            else
            begin
                got = exp_q.pop_front();
                cmp("fault", 32'(got.f), 32'(gp_fault_q));
                cmp("lin", got.lin, rsp_lin_q);
                cmp("lanes", 32'(got.be), 32'(rsp_be_q));
                if (got.f)
                    cmp("err", 32'(got.err), 32'(gp_err_q));
            end
        end
    end

    // ==========================================
    // main sequence
    initial
    begin
        {fail_count, checks_done} = 0;
        seed = 88201;
        {nrst, prot_enable, gtb_wr, ltb_wr, req_valid, req_write, req_cs_load} = 7'h0;
        {gtb_data, ltb_data, req_off, req_sel, req_size, lag} = '0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge clk);
        cmp("prot_mode", 32'h0, 32'(prot_mode_q));
        for (i = 0; i < 6; i++)
        begin
            sv = 16'($random(seed));
            o = $random(seed);
            send(sv, o, rsz(), i[0], 1'b0, 1'b0, {12'h0, sv, 4'h0}, 16'h0);
        end
        drain();
        cmp("prot_mode", 32'h0, 32'(prot_mode_q));
        sat_mem_model_inst.put_desc(GTB + 32'h08, dsc(B1, 4'h2, 2'h0, 1'b1));
        sat_mem_model_inst.put_desc(GTB + 32'h10, dsc(B1, 4'h2, 2'h0, 1'b0));
        sat_mem_model_inst.put_desc(GTB + 32'h18, dsc(B1, 4'h0, 2'h0, 1'b1));
        sat_mem_model_inst.put_desc(GTB + 32'h20, dsc(B1, 4'h2, 2'h1, 1'b1));
        sat_mem_model_inst.put_desc(GTB + 32'h28, dsc(B5, 4'ha, 2'h3, 1'b1));
        sat_mem_model_inst.put_desc(LTB + 32'h08, dsc(B2, 4'h2, 2'h3, 1'b1));
        tbl(1'b0, GTB);
        @(posedge clk);
        #1;
        prot_enable = 1'b1;
        tbl(1'b0, GTB);
        cmp("prot_mode", 32'h1, 32'(prot_mode_q));
        o = $random(seed);
        send(16'h0003, o, 2'h0, 1'b0, 1'b0, 1'b1, B1, 16'h0000);
        send(16'h000c, o, 2'h0, 1'b0, 1'b0, 1'b1, B1, 16'h0000);
        for (i = 0; i < 4; i++)
            send(16'h0008, $random(seed), rsz(), i[0], 1'b0, 1'b0, B1, 16'h0);
        send(16'h0011, o, 2'h0, 1'b0, 1'b0, 1'b1, B1, 16'h0010);
        send(16'h0018, o, 2'h1, 1'b1, 1'b0, 1'b1, B1, 16'h0018);
        send(16'h0022, o, 2'h0, 1'b0, 1'b0, 1'b1, B1, 16'h0020);
        tbl(1'b1, LTB);
        send(16'h000c, o, 2'h2, 1'b1, 1'b0, 1'b0, B2, 16'h0);
        send(16'h002b, o, 2'h2, 1'b0, 1'b1, 1'b0, B5, 16'h0);
        drain();
        cmp("cpl", 32'h3, 32'(cpl_q));
        send(16'h0008, o, 2'h0, 1'b0, 1'b0, 1'b1, B1, 16'h0008);
        send(16'h002b, o, 2'h0, 1'b1, 1'b0, 1'b1, B5, 16'h0028);
        send(16'h000c, o, 2'h1, 1'b0, 1'b0, 1'b0, B2, 16'h0);
        drain();
        #1;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge clk);
        cmp("prot_mode", 32'h0, 32'(prot_mode_q));
        cmp("cpl", 32'h0, 32'(cpl_q));
        conclude();
    end
endmodule // sat_translate_test
